//--- include/ee_ctrl_pkg.sv
// shared constants and types for the eeprom program/erase controller
package ee_ctrl_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] ARRAY_BASE = 16'h0800;
    localparam logic [15:0] ARRAY_LAST = 16'h09FF;
    localparam logic [15:0] SECURE_BASE = 16'h08F0;
    localparam logic [15:0] SECURE_LAST = 16'h08FF;
    localparam int BLOCK_LSB = 7;
    localparam int ARRAY_IDX_W = 9;
    // control register byte addresses (chosen)
    localparam logic [15:0] CTRL_ADDR = 16'h0040;
    localparam logic [15:0] ACFG_ADDR = 16'h0041;
    // control register field positions
    localparam int CTL_SPARE = 7;
    localparam int CTL_PDOWN = 6;
    localparam int CTL_MODE_HI = 5;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_LAT = 3;
    localparam int CTL_AUTO = 1;
    localparam int CTL_PGM = 0;
    // array config field positions
    localparam int ACR_SPARE_HI = 7;
    localparam int ACR_SPARE_LO = 5;
    localparam int ACR_SEC = 4;
    localparam int ACR_BP_HI = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ACFG_RESET = 8'hF0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // auto timer durations, microseconds, and counts at 50 MHz
    localparam int CLK_MHZ = 50;
    localparam int BYTE_PGM_US = 8;
    localparam int BYTE_ERASE_US = 8;
    localparam int BLOCK_ERASE_US = 8;
    localparam int BULK_ERASE_US = 8;
    localparam int TIMER_W = 20;

    typedef enum logic [1:0] {
        MODE_BYTE_PGM,
        MODE_BYTE_ERASE,
        MODE_BLOCK_ERASE,
        MODE_BULK_ERASE
    } op_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic hv_on;
        op_mode_t mode;
        logic [8:0] idx;
        logic [7:0] data;
    } hv_cmd_t;
endpackage

//--- rtl/ee_auto_timer.sv
// auto-termination timer for one program/erase cycle
`timescale 1ns/1ps
module ee_auto_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [19:0] load_cycles,
    output logic done
);
    logic [19:0] cnt_q;
    logic busy_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy_q <= 1'b0;
            end else if (start) begin
                cnt_q <= load_cycles;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q <= 20'h00001) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 20'h00001;
                end
            end
        end
    end
endmodule

//--- rtl/ee_ctrl.sv
// eeprom program/erase control: registers, latch, protection, array
`timescale 1ns/1ps
module ee_ctrl #(
    parameter logic [7:0] NV_CONFIG = ee_ctrl_pkg::ACFG_RESET
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    output logic hv_on,
    output logic cycle_failed
);
    localparam int ARRAY_BYTES = 512;
    localparam logic [19:0] T_BYTE_PGM =
        20'(ee_ctrl_pkg::BYTE_PGM_US * ee_ctrl_pkg::CLK_MHZ);
    localparam logic [19:0] T_BYTE_ERASE =
        20'(ee_ctrl_pkg::BYTE_ERASE_US * ee_ctrl_pkg::CLK_MHZ);
    localparam logic [19:0] T_BLOCK_ERASE =
        20'(ee_ctrl_pkg::BLOCK_ERASE_US * ee_ctrl_pkg::CLK_MHZ);
    localparam logic [19:0] T_BULK_ERASE =
        20'(ee_ctrl_pkg::BULK_ERASE_US * ee_ctrl_pkg::CLK_MHZ);

    function automatic logic in_array(input logic [15:0] a);
        return a >= ee_ctrl_pkg::ARRAY_BASE && a <= ee_ctrl_pkg::ARRAY_LAST;
    endfunction

    function automatic logic [8:0] arr_idx(input logic [15:0] a);
        logic [15:0] off;
        off = a - ee_ctrl_pkg::ARRAY_BASE;
        return off[8:0];
    endfunction

    ee_ctrl_pkg::bus_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

    logic [7:0] mem [ARRAY_BYTES];
    logic spare_q;
    logic pdown_q;
    ee_ctrl_pkg::op_mode_t mode_q;
    logic lat_q;
    logic auto_q;
    logic pgm_q;
    logic valid_q;
    logic [8:0] lat_idx_q;
    logic [7:0] lat_data_q;
    logic [2:0] acr_spare_q;
    logic sec_en_q;
    logic [3:0] bp_q;
    logic failed_q;
    logic timer_done;

    logic wr_ctrl, wr_acfg, arr_wr, arr_rd, pgm_set, allowed;
    logic [1:0] blk;
    logic [19:0] dur;
    assign wr_ctrl = req.wr && req.addr == ee_ctrl_pkg::CTRL_ADDR;
    assign wr_acfg = req.wr && req.addr == ee_ctrl_pkg::ACFG_ADDR;
    assign arr_wr = req.wr && in_array(req.addr);
    assign arr_rd = req.rd && in_array(req.addr);
    assign blk = lat_idx_q[ee_ctrl_pkg::ARRAY_IDX_W-1:ee_ctrl_pkg::BLOCK_LSB];

    // protection check against the captured target
    always_comb begin
        allowed = !bp_q[blk];
        if (!sec_en_q) begin
            if (mode_q == ee_ctrl_pkg::MODE_BLOCK_ERASE ||
                mode_q == ee_ctrl_pkg::MODE_BULK_ERASE) begin
                allowed = 1'b0;
            end
            if ({7'h00, lat_idx_q} >= (ee_ctrl_pkg::SECURE_BASE -
                    ee_ctrl_pkg::ARRAY_BASE) &&
                {7'h00, lat_idx_q} <= (ee_ctrl_pkg::SECURE_LAST -
                    ee_ctrl_pkg::ARRAY_BASE)) begin
                allowed = 1'b0;
            end
        end
    end

    assign pgm_set = wr_ctrl && req.wdata[ee_ctrl_pkg::CTL_PGM] && !pgm_q &&
        lat_q && valid_q && allowed;

    always_comb begin
        case (mode_q)
            ee_ctrl_pkg::MODE_BYTE_PGM: dur = T_BYTE_PGM;
            ee_ctrl_pkg::MODE_BYTE_ERASE: dur = T_BYTE_ERASE;
            ee_ctrl_pkg::MODE_BLOCK_ERASE: dur = T_BLOCK_ERASE;
            ee_ctrl_pkg::MODE_BULK_ERASE: dur = T_BULK_ERASE;
            default: dur = T_BYTE_PGM;
        endcase
    end

    // runs in both modes: the array only changes after a full cycle
    ee_auto_timer u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(pgm_set),
        .abort(!pgm_q && !pgm_set),
        .load_cycles(dur),
        .done(timer_done)
    );

    // control register; with the latch set, writes gated until a valid array write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spare_q <= 1'b0;
            pdown_q <= 1'b0;
            mode_q <= ee_ctrl_pkg::MODE_BYTE_PGM;
            lat_q <= 1'b0;
            auto_q <= 1'b0;
            pgm_q <= 1'b0;
        end else begin
            if (wr_ctrl && (!lat_q || valid_q)) begin
                spare_q <= req.wdata[ee_ctrl_pkg::CTL_SPARE];
                pdown_q <= req.wdata[ee_ctrl_pkg::CTL_PDOWN];
                mode_q <= ee_ctrl_pkg::op_mode_t'(req.wdata[
                    ee_ctrl_pkg::CTL_MODE_HI:ee_ctrl_pkg::CTL_MODE_LO]);
                auto_q <= req.wdata[ee_ctrl_pkg::CTL_AUTO];
                if (pgm_set) begin
                    pgm_q <= 1'b1;
                end else if (!req.wdata[ee_ctrl_pkg::CTL_PGM]) begin
                    pgm_q <= 1'b0;
                end
                // latch may only drop with enable already clear
                if (req.wdata[ee_ctrl_pkg::CTL_LAT] || !pgm_q) begin
                    lat_q <= req.wdata[ee_ctrl_pkg::CTL_LAT];
                end
            end else if (wr_ctrl && !req.wdata[ee_ctrl_pkg::CTL_LAT]) begin
                // release of the latch is always honoured when idle
                if (!pgm_q) begin
                    lat_q <= 1'b0;
                end
            end
            if (timer_done && auto_q) begin
                pgm_q <= 1'b0;
            end
        end
    end

    // address/data capture while latching
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            valid_q <= 1'b0;
            lat_idx_q <= '0;
            lat_data_q <= '0;
        end else if (!lat_q) begin
            valid_q <= 1'b0;
        end else if (!pgm_q) begin
            if (arr_wr) begin
                valid_q <= 1'b1;
                lat_idx_q <= arr_idx(req.addr);
                lat_data_q <= req.wdata;
            end else if (arr_rd) begin
                lat_idx_q <= arr_idx(req.addr);
            end
        end
    end

    // read during a running cycle spoils it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            failed_q <= 1'b0;
        end else if (pgm_set) begin
            failed_q <= 1'b0;
        end else if (pgm_q && arr_rd) begin
            failed_q <= 1'b1;
        end
    end

    // array config: image of the nonvolatile copy, taken at reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acr_spare_q <= NV_CONFIG[ee_ctrl_pkg::ACR_SPARE_HI:
                ee_ctrl_pkg::ACR_SPARE_LO];
            bp_q <= NV_CONFIG[ee_ctrl_pkg::ACR_BP_HI:0];
        end else if (wr_acfg) begin
            acr_spare_q <= req.wdata[ee_ctrl_pkg::ACR_SPARE_HI:
                ee_ctrl_pkg::ACR_SPARE_LO];
        end
    end

    // no write path to the security bit: once armed it stays armed
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sec_en_q <= NV_CONFIG[ee_ctrl_pkg::ACR_SEC];
        end else if (!sec_en_q) begin
            sec_en_q <= 1'b0;
        end
    end

    // array contents: erase to ones, program only clears bits
    logic hv_act;
    assign hv_act = pgm_q && !failed_q;
    always_ff @(posedge ref_clk) begin
        if (hv_act && timer_done) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                case (mode_q)
                    ee_ctrl_pkg::MODE_BYTE_PGM: begin
                        if (9'(i) == lat_idx_q) begin
                            mem[i] <= mem[i] & lat_data_q;
                        end
                    end
                    ee_ctrl_pkg::MODE_BYTE_ERASE: begin
                        if (9'(i) == lat_idx_q) begin
                            mem[i] <= ee_ctrl_pkg::ERASED_BYTE;
                        end
                    end
                    ee_ctrl_pkg::MODE_BLOCK_ERASE: begin
                        if (2'(i >> ee_ctrl_pkg::BLOCK_LSB) == blk) begin
                            mem[i] <= ee_ctrl_pkg::ERASED_BYTE;
                        end
                    end
                    ee_ctrl_pkg::MODE_BULK_ERASE: begin
                        if (!bp_q[2'(i >> ee_ctrl_pkg::BLOCK_LSB)]) begin
                            mem[i] <= ee_ctrl_pkg::ERASED_BYTE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read data, registered one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (req.rd) begin
            if (req.addr == ee_ctrl_pkg::CTRL_ADDR) begin
                rdata <= {spare_q, pdown_q, mode_q, lat_q, 1'b0, auto_q,
                    pgm_q};
            end else if (req.addr == ee_ctrl_pkg::ACFG_ADDR) begin
                rdata <= {acr_spare_q, sec_en_q, bp_q};
            end else if (in_array(req.addr)) begin
                if (lat_q) begin
                    rdata <= lat_data_q;
                end else if (pdown_q) begin
                    rdata <= ee_ctrl_pkg::ERASED_BYTE;
                end else begin
                    rdata <= mem[arr_idx(req.addr)];
                end
            end else begin
                rdata <= '0;
            end
        end else begin
            rdata <= '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hv_on <= 1'b0;
            cycle_failed <= 1'b0;
        end else begin
            hv_on <= pgm_set || (pgm_q && !(timer_done && auto_q));
            cycle_failed <= failed_q;
        end
    end

    property p_pgm_needs_latch;
        @(posedge ref_clk) disable iff (rst)
        $rose(pgm_q) |-> $past(lat_q) && $past(valid_q);
    endproperty
    a_pgm_needs_latch: assert property (p_pgm_needs_latch)
        else $error("enable set without valid latch");

    property p_lat_held;
        @(posedge ref_clk) disable iff (rst)
        $past(pgm_q) |-> lat_q;
    endproperty
    a_lat_held: assert property (p_lat_held)
        else $error("latch cleared while enable was set");

    property p_both_clear;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl && pgm_q && !req.wdata[ee_ctrl_pkg::CTL_PGM] &&
        !req.wdata[ee_ctrl_pkg::CTL_LAT] |=> lat_q && !pgm_q;
    endproperty
    a_both_clear: assert property (p_both_clear)
        else $error("double clear dropped the latch");

    property p_hv_follows;
        @(posedge ref_clk) disable iff (rst)
        pgm_q |-> hv_on;
    endproperty
    a_hv_follows: assert property (p_hv_follows)
        else $error("high voltage missing while enabled");

    property p_hv_allowed;
        @(posedge ref_clk) disable iff (rst)
        $rose(hv_on) |-> $past(allowed) && $past(lat_q) && $past(valid_q);
    endproperty
    a_hv_allowed: assert property (p_hv_allowed)
        else $error("high voltage raised for a refused target");

    property p_read_spoils;
        @(posedge ref_clk) disable iff (rst)
        pgm_q && arr_rd |=> failed_q;
    endproperty
    a_read_spoils: assert property (p_read_spoils)
        else $error("array read during enable not flagged");
endmodule

//--- verification/cpu_bus_model.sv
// cpu-side bus master model for the eeprom controller
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic ref_clk,
    output logic [15:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 16'h0000;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // idle bus flips so nothing can lean on stale values
    task automatic release_bus();
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        release_bus();
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        release_bus();
        #1;
        d = rdata;
    endtask
endmodule

//--- verification/testbench.sv
// directed register-level tests of the eeprom program/erase controller
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] CTRL = ee_ctrl_pkg::CTRL_ADDR;
    localparam logic [15:0] ACFG = ee_ctrl_pkg::ACFG_ADDR;
    // decay wait, generous margin since no figure is fixed
    localparam int FALL_CYCLES = 50;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr, addr2;
    logic [7:0] wdata, wdata2, rdata, rdata2, v;
    logic wr_stb, rd_stb, wr_stb2, rd_stb2, hv_on, hv_on2, failed;
    int errors = 0;
    int tests_run = 0;

    always #10 ref_clk = ~ref_clk;

    cpu_bus_model bm (.ref_clk(ref_clk), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
    ee_ctrl dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .hv_on(hv_on),
        .cycle_failed(failed));
    // second device: block 0 protected, security armed
    cpu_bus_model bm2 (.ref_clk(ref_clk), .addr(addr2), .wdata(wdata2),
        .wr_stb(wr_stb2), .rd_stb(rd_stb2), .rdata(rdata2));
    ee_ctrl #(.NV_CONFIG(8'h01)) dut2 (.ref_clk(ref_clk), .rst(rst),
        .addr(addr2), .wdata(wdata2), .wr_stb(wr_stb2), .rd_stb(rd_stb2),
        .rdata(rdata2), .hv_on(hv_on2), .cycle_failed());

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bm.rd(a, d);
        check(d, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // bounded poll, never relying on the exact auto delay
    task automatic wait_hv_low();
        int n;
        n = 0;
        while (hv_on === 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic run_auto(input ee_ctrl_pkg::op_mode_t m,
        input logic [15:0] a, input logic [7:0] d);
        bm.wr(CTRL, {2'h0, m, 4'hA});
        bm.wr(a, d);
        bm.wr(CTRL, {2'h0, m, 4'hB});
        settle();
        check({7'h00, hv_on}, 8'h01);
        wait_hv_low();
        check({7'h00, hv_on}, 8'h00);
        rchk(CTRL, {2'h0, m, 4'hA});
        bm.wr(CTRL, 8'h00);
    endtask

    task automatic try2(input ee_ctrl_pkg::op_mode_t m,
        input logic [15:0] a, input logic exp);
        bm2.wr(CTRL, {2'h0, m, 4'h8});
        bm2.wr(a, 8'h00);
        bm2.wr(CTRL, {2'h0, m, 4'h9});
        settle();
        check({7'h00, hv_on2}, {7'h00, exp});
        bm2.wr(CTRL, 8'h00);
        repeat (FALL_CYCLES) @(posedge ref_clk);
        bm2.wr(CTRL, 8'h00);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rchk(CTRL, ee_ctrl_pkg::CTRL_RESET);
        rchk(ACFG, 8'hF0);
        for (int i = 0; i < 4; i++) begin
            bm.wr(CTRL, {2'h2, i[1:0], 4'h2});
            rchk(CTRL, {2'h2, i[1:0], 4'h2});
        end
        bm.wr(ACFG, 8'hEF);
        rchk(ACFG, 8'hF0);
        bm.wr(ACFG, 8'h0F);
        rchk(ACFG, 8'h10);
        bm.wr(CTRL, 8'h01);
        settle();
        check({7'h00, hv_on}, 8'h00);
        rchk(CTRL, 8'h00);
        bm.wr(CTRL, 8'h08);
        bm.wr(CTRL, 8'h09);
        settle();
        check({7'h00, hv_on}, 8'h00);
        rchk(CTRL, 8'h08);
        bm.wr(CTRL, 8'h00);
        rchk(CTRL, 8'h00);
        end_test("control");
        run_auto(ee_ctrl_pkg::MODE_BYTE_ERASE, 16'h0900, 8'h00);
        rchk(16'h0900, 8'hFF);
        run_auto(ee_ctrl_pkg::MODE_BYTE_PGM, 16'h0900, 8'h3C);
        rchk(16'h0900, 8'h3C);
        run_auto(ee_ctrl_pkg::MODE_BLOCK_ERASE, 16'h097F, 8'h00);
        rchk(16'h0900, 8'hFF);
        run_auto(ee_ctrl_pkg::MODE_BYTE_PGM, 16'h0901, 8'h5A);
        run_auto(ee_ctrl_pkg::MODE_BULK_ERASE, 16'h0800, 8'h00);
        rchk(16'h0901, 8'hFF);
        run_auto(ee_ctrl_pkg::MODE_BYTE_PGM, 16'h0980, 8'h0F);
        run_auto(ee_ctrl_pkg::MODE_BLOCK_ERASE, 16'h0900, 8'h00);
        rchk(16'h0980, 8'h0F);
        end_test("auto");
        bm.wr(CTRL, 8'h08);
        bm.wr(16'h0042, 8'h11);
        bm.wr(16'h0810, 8'hA5);
        bm.wr(16'h0811, 8'h96);
        rchk(16'h0811, 8'h96);
        rchk(16'h0812, 8'h96);
        bm.wr(CTRL, 8'h09);
        settle();
        check({7'h00, hv_on}, 8'h01);
        repeat (450) @(posedge ref_clk);
        #1;
        check({7'h00, hv_on}, 8'h01);
        bm.wr(CTRL, 8'h00);
        settle();
        check({7'h00, hv_on}, 8'h00);
        rchk(CTRL, 8'h08);
        repeat (FALL_CYCLES) @(posedge ref_clk);
        bm.wr(CTRL, 8'h00);
        rchk(CTRL, 8'h00);
        rchk(16'h0812, 8'h96);
        rchk(16'h0811, 8'hFF);
        end_test("manual");
        bm.wr(CTRL, 8'h1A);
        bm.wr(16'h0830, 8'h00);
        bm.wr(CTRL, 8'h1B);
        // spoiling read on purpose
        bm.rd(16'h0830, v);
        settle();
        check({7'h00, failed}, 8'h01);
        wait_hv_low();
        bm.wr(CTRL, 8'h00);
        bm.wr(CTRL, 8'h40);
        rchk(CTRL, 8'h40);
        rchk(16'h0980, 8'hFF);
        bm.wr(CTRL, 8'h00);
        end_test("fault");
        bm2.rd(ACFG, v);
        check(v, 8'h01);
        try2(ee_ctrl_pkg::MODE_BYTE_PGM, 16'h0810, 1'b0);
        try2(ee_ctrl_pkg::MODE_BYTE_PGM, 16'h08F5, 1'b0);
        try2(ee_ctrl_pkg::MODE_BYTE_ERASE, 16'h08F0, 1'b0);
        try2(ee_ctrl_pkg::MODE_BLOCK_ERASE, 16'h0900, 1'b0);
        try2(ee_ctrl_pkg::MODE_BULK_ERASE, 16'h0900, 1'b0);
        try2(ee_ctrl_pkg::MODE_BYTE_ERASE, 16'h0900, 1'b1);
        bm2.wr(ACFG, 8'hFF);
        bm2.rd(ACFG, v);
        check(v, 8'hE1);
        end_test("protect");
        print_verdict();
    end
endmodule
